// File: dma_master_pkg.sv
// shared constants and carriers for the descriptor and fifo bus master
package dma_master_pkg;

    // ****************************************************
    // bus commands and lane masks (cbe_n, active low)
    // ****************************************************
    localparam logic [3:0] CMD_MEM_READ   = 4'h6;   // memory read
    localparam logic [3:0] CMD_MEM_WRITE  = 4'h7;   // memory write
    localparam logic [3:0] BE_ALL_LANES   = 4'h0;   // whole dword
    localparam logic [3:0] BE_TOP_BYTE    = 4'h7;   // lane 3 only
    localparam logic [3:0] BE_TOP_HALF    = 4'h3;   // lanes 3 and 2

    // ****************************************************
    // descriptor layout and structure styles
    // ****************************************************
    localparam logic [7:0] DESC_OFF_00    = 8'h00;  // first dword
    localparam logic [7:0] DESC_OFF_04    = 8'h04;  // second dword
    localparam logic [7:0] DESC_OFF_08    = 8'h08;  // third dword
    localparam logic [7:0] STYLE_16BIT    = 8'h00;  // 16-bit structures
    localparam logic [7:0] STYLE_32BIT    = 8'h02;  // 32-bit structures
    localparam logic [7:0] STYLE_BURST    = 8'h03;  // 32-bit, burst order

    // ****************************************************
    // address stepping
    // ****************************************************
    localparam logic [31:0] ADDR_STEP     = 32'h0000_0004; // one dword
    localparam logic [1:0]  LINEAR_ORDER  = 2'h0;          // ad[1:0]

    // one descriptor write request from the buffer manager
    typedef struct packed {
        logic [31:0] base;                    // descriptor start address
        logic [31:0] descriptor_word_one;     // status and ownership
        logic [31:0] descriptor_word_two;     // counts / extra status
        logic [7:0]  software_structure_style;
        logic        burst_write_enable;
    } desc_req_t;

    // one planned descriptor data phase
    typedef struct packed {
        logic [7:0]  offset;                  // offset from base
        logic [31:0] data;                    // lane-placed data
        logic [3:0]  be_n;                    // active-low lanes
    } desc_step_t;

endpackage

// File: desc_write_plan.sv
// lookup of address, data and lanes for each descriptor write phase
`timescale 1ns/100ps
`default_nettype none

module desc_write_plan
    import dma_master_pkg::*;
(
    input  wire desc_req_t  req,
    input  wire logic       phase_idx,
    output var  desc_step_t step,
    output var  logic       burst
);

    // ****************************************************
    // style decode
    // ****************************************************
    wire logic is_style16 = (req.software_structure_style == STYLE_16BIT);
    wire logic is_style3  = (req.software_structure_style == STYLE_BURST);

    // burst only in the burst-ordered style; other styles ignore it
    assign burst = is_style3 && req.burst_write_enable;

    // short names for the two words
    wire logic [31:0] w1 = req.descriptor_word_one;
    wire logic [31:0] w2 = req.descriptor_word_two;

    // ****************************************************
    // phase table
    // ****************************************************
    // unknown style codes fall back to the plain 32-bit layout
    always_comb begin
        if (is_style16) begin
            if (!phase_idx) begin
                // low halves of both words first
                step = '{DESC_OFF_04, {w2[15:0], w1[15:0]}, BE_ALL_LANES};
            end else begin
                // ownership byte last so software sees it after status
                step = '{DESC_OFF_00, {w1[31:24], 24'h000000}, BE_TOP_BYTE};
            end
        end else if (is_style3) begin
            if (!phase_idx) begin
                step = '{DESC_OFF_00, w2, BE_ALL_LANES};
            end else begin
                step = '{DESC_OFF_04, {w1[31:16], 16'h0000}, BE_TOP_HALF};
            end
        end else begin
            if (!phase_idx) begin
                step = '{DESC_OFF_08, w2, BE_ALL_LANES};
            end else begin
                step = '{DESC_OFF_04, {w1[31:16], 16'h0000}, BE_TOP_HALF};
            end
        end
    end

endmodule
`default_nettype wire

// File: dma_bus_master.sv
// bus master sequencer for descriptor status writes and fifo data moves
//
// Notes on behaviour
// - 16-bit style: offset 04 then byte at 00
// - style 2: word two at 08, then 04
// - style 3: 00 then 04, burst if enabled
// - internal logic requests fifo data transfers
// - after grant, run consecutive transfers then release; req_n is dropped in ST_GAP after every transfer
// - one mastership period: all reads or writes
// - fifo transfers use ascending contiguous addresses
// - fifo transfers support non-burst and burst
// - descriptor writes: one irdy wait per phase
// - burst descriptor write only style 3 enabled
// - non-burst: frame drops after each address
// - address bits 1:0 zero, linear burst order
`timescale 1ns/100ps
`default_nettype none

module dma_bus_master
    import dma_master_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        nrst,
    // descriptor write request
    input  wire logic        desc_start,
    input  wire desc_req_t   desc_req,
    // fifo transfer request
    input  wire logic        fifo_start,
    input  wire logic        fifo_read,
    input  wire logic        fifo_burst,
    input  wire logic [31:0] fifo_addr,
    input  wire logic        fifo_more,
    // fifo write stream (fifo to memory)
    input  wire logic        wr_valid,
    input  wire logic [31:0] wr_data,
    output logic             wr_ready,
    // fifo read stream (memory to fifo)
    output logic             rd_valid,
    output logic [31:0]      rd_data,
    // status
    output logic             busy,
    output logic             done,
    // arbitration
    output logic             req_n,
    input  wire logic        gnt_n,
    // bus pins, split into in / out / enable
    input  wire logic        frame_n_in,
    output logic             frame_n_out,
    output logic             frame_n_oe,
    input  wire logic        irdy_n_in,
    output logic             irdy_n_out,
    output logic             irdy_n_oe,
    input  wire logic        trdy_n,
    input  wire logic [31:0] ad_in,
    output logic [31:0]      ad_out,
    output logic             ad_oe,
    output logic [3:0]       cbe_n_out,
    output logic             cbe_n_oe
);

    // ****************************************************
    // state and registers
    // ****************************************************
    typedef enum logic [2:0] {
        ST_IDLE, ST_REQ, ST_ADDR, ST_WAIT, ST_DATA, ST_GAP
    } state_t;

    state_t      state_q, state_d;   // sequencer state
    desc_req_t   desc_q, desc_d;     // captured descriptor request
    logic        is_desc_q, is_desc_d; // descriptor or fifo period
    logic        dir_read_q, dir_read_d; // direction of this period
    logic        fburst_q, fburst_d; // fifo burst allowed
    logic        idx_q, idx_d;       // descriptor phase index
    logic        last_q, last_d;     // current data phase is final
    logic        more_q, more_d;     // another transfer after the gap
    logic [31:0] addr_q, addr_d;     // current transfer address
    logic [31:0] ad_q, ad_d;         // driven ad value
    logic [3:0]  cbe_q, cbe_d;       // driven command / lanes
    logic        rd_valid_q;         // read word strobe
    logic [31:0] rd_data_q;          // read word

    // ****************************************************
    // descriptor phase lookup
    // ****************************************************
    desc_step_t  step;               // planned phase
    logic        desc_burst;         // descriptor burst selected

    // a burst continuation always moves to the second phase
    wire logic phase_idx = (state_q == ST_DATA) ? 1'b1 : idx_q;

    desc_write_plan u_plan (
        .req       (desc_q),
        .phase_idx (phase_idx),
        .step      (step),
        .burst     (desc_burst)
    );

    // ****************************************************
    // decode wires
    // ****************************************************
    // wait for an idle bus so we never collide with the last owner
    wire logic bus_ok   = !gnt_n && frame_n_in && irdy_n_in;
    wire logic data_ack = (state_q == ST_DATA) && !trdy_n;
    wire logic fifo_wr  = !is_desc_q && !dir_read_q;

    // start address of the next transfer
    wire logic [31:0] desc_addr = desc_q.base + {24'h000000, step.offset};
    wire logic [31:0] next_addr = is_desc_q ? desc_addr : addr_q;

    // direction is fixed for the whole period
    wire logic [3:0] cmd = dir_read_q ? CMD_MEM_READ : CMD_MEM_WRITE;

    // data and lanes of the phase about to start
    wire logic [31:0] phase_data = is_desc_q ? step.data
                                 : (dir_read_q ? 32'h0000_0000 : wr_data);
    wire logic [3:0]  phase_be   = is_desc_q ? step.be_n : BE_ALL_LANES;

    // descriptor: final unless burst and first phase
    // fifo: final when non-burst, no more wanted, or grant taken away
    wire logic fifo_last  = !fburst_q || !fifo_more || gnt_n;
    wire logic phase_last = is_desc_q ? !(desc_burst && !phase_idx)
                                      : fifo_last;

    // another separate transfer after this one completes
    wire logic again = is_desc_q ? !idx_q
                     : (fifo_more && (dir_read_q || wr_valid));

    // ****************************************************
    // next-state logic
    // ****************************************************
    // one process keeps the phase loading in a single place
    always_comb begin
        state_d    = state_q;
        desc_d     = desc_q;
        is_desc_d  = is_desc_q;
        dir_read_d = dir_read_q;
        fburst_d   = fburst_q;
        idx_d      = idx_q;
        last_d     = last_q;
        more_d     = more_q;
        addr_d     = addr_q;
        ad_d       = ad_q;
        cbe_d      = cbe_q;
        wr_ready   = 1'b0;
        case (state_q)
            ST_IDLE: begin
                // descriptor writes take priority over fifo moves
                if (desc_start) begin
                    desc_d     = desc_req;
                    is_desc_d  = 1'b1;
                    dir_read_d = 1'b0;
                    idx_d      = 1'b0;
                    state_d    = ST_REQ;
                end else if (fifo_start) begin
                    // fifo moves requested by the internal sequencer
                    is_desc_d  = 1'b0;
                    dir_read_d = fifo_read;
                    fburst_d   = fifo_burst;
                    addr_d     = {fifo_addr[31:2], LINEAR_ORDER};
                    state_d    = ST_REQ;
                end
            end
            ST_REQ: begin
                // address phase with linear burst order
                if (bus_ok) begin
                    addr_d  = {next_addr[31:2], LINEAR_ORDER};
                    ad_d    = {next_addr[31:2], LINEAR_ORDER};
                    cbe_d   = cmd;
                    state_d = ST_ADDR;
                end
            end
            ST_ADDR: begin
                // first data phase of the transfer
                ad_d     = phase_data;
                cbe_d    = phase_be;
                last_d   = phase_last;
                wr_ready = fifo_wr;
                // descriptor writes insert a wait state
                state_d  = is_desc_q ? ST_WAIT : ST_DATA;
            end
            ST_WAIT: begin
                state_d = ST_DATA;
            end
            ST_DATA: begin
                if (!trdy_n) begin
                    addr_d = addr_q + ADDR_STEP;
                    if (last_q) begin
                        // final phase, burst or not: new address phase per transfer
                        idx_d   = 1'b1;
                        more_d  = again;
                        state_d = ST_GAP;
                    end else begin
                        // burst continuation, next dword
                        idx_d    = 1'b1;
                        ad_d     = phase_data;
                        cbe_d    = phase_be;
                        last_d   = phase_last;
                        wr_ready = fifo_wr;
                        state_d  = is_desc_q ? ST_WAIT : ST_DATA;
                    end
                end
            end
            ST_GAP: begin
                // idle cycle, then keep going while work remains
                state_d = more_q ? ST_REQ : ST_IDLE;
            end
            default: begin
                state_d = ST_IDLE;
            end
        endcase
    end

    // ****************************************************
    // registers
    // ****************************************************
    // sequencer state, synchronous active-low reset
    always_ff @(posedge clk) begin
        if (!nrst) begin
            state_q <= ST_IDLE;
        end else begin
            state_q <= state_d;
        end
    end

    // request context; value only matters once a request is taken
    always_ff @(posedge clk) begin
        if (!nrst) begin
            desc_q     <= '0;
            is_desc_q  <= 1'b0;
            dir_read_q <= 1'b0;
            fburst_q   <= 1'b0;
            idx_q      <= 1'b0;
        end else begin
            desc_q     <= desc_d;
            is_desc_q  <= is_desc_d;
            dir_read_q <= dir_read_d;
            fburst_q   <= fburst_d;
            idx_q      <= idx_d;
        end
    end

    // address and pin drive registers
    always_ff @(posedge clk) begin
        if (!nrst) begin
            last_q <= 1'b1;
            more_q <= 1'b0;
            addr_q <= 32'h0000_0000;
            ad_q   <= 32'h0000_0000;
            cbe_q  <= 4'hF;
        end else begin
            last_q <= last_d;
            more_q <= more_d;
            addr_q <= addr_d;
            ad_q   <= ad_d;
            cbe_q  <= cbe_d;
        end
    end

    // read words are captured on the cycle the target is ready
    always_ff @(posedge clk) begin
        if (!nrst) begin
            rd_valid_q <= 1'b0;
            rd_data_q  <= 32'h0000_0000;
        end else begin
            rd_valid_q <= data_ack && dir_read_q && !is_desc_q;
            if (data_ack && dir_read_q) begin
                rd_data_q <= ad_in;
            end
        end
    end

    // ****************************************************
    // pin decode
    // ****************************************************
    wire logic in_phase = (state_q == ST_WAIT) || (state_q == ST_DATA);
    wire logic owning   = (state_q == ST_ADDR) || in_phase
                       || (state_q == ST_GAP);

    // frame held only while more data phases follow
    assign frame_n_out = !((state_q == ST_ADDR) || (in_phase && !last_q));
    assign frame_n_oe  = owning;
    // irdy stays high during the descriptor wait state
    assign irdy_n_out  = !(state_q == ST_DATA);
    assign irdy_n_oe   = owning;
    assign ad_out      = ad_q;
    // reads release ad for the target after the address phase
    assign ad_oe       = (state_q == ST_ADDR) || (in_phase && !dir_read_q);
    assign cbe_n_out   = cbe_q;
    assign cbe_n_oe    = (state_q == ST_ADDR) || in_phase;
    // request held from ST_REQ through the data phases, dropped in the ST_GAP cycle
    assign req_n       = !((state_q == ST_REQ) || (state_q == ST_ADDR)
                        || in_phase);
    assign rd_valid    = rd_valid_q;
    assign rd_data     = rd_data_q;
    assign busy        = (state_q != ST_IDLE);
    assign done        = (state_q == ST_GAP) && !more_q;

endmodule
`default_nettype wire

// File: dma_bus_master_asserts.sv
// concurrent checks on the bus master ports
`timescale 1ns/100ps
`default_nettype none

module dma_bus_master_asserts
    import dma_master_pkg::*;
(
    input wire logic        clk, nrst, desc_start, fifo_start, fifo_read,
    input wire logic        fifo_burst, rd_valid, busy, req_n, gnt_n, ad_oe,
    input wire logic        frame_n_out, irdy_n_out, trdy_n,
    input wire desc_req_t   desc_req,
    input wire logic [31:0] fifo_addr, ad_in, ad_out, rd_data,
    input wire logic [3:0]  cbe_n_out
);
    // ******************************
    // period tracking
    // ******************************
    logic        desc_q, fifo_q, rd_q, nb_q, seen_q; // mode of this period
    logic [3:0]  cmd_q;                            // last command issued
    logic [31:0] nxt_q;                            // next fifo address
    wire         go = !busy && (desc_start || fifo_start);
    wire         bdesc = desc_req.software_structure_style == STYLE_BURST
                         && desc_req.burst_write_enable;

    default clocking @(posedge clk); endclocking
    default disable iff (!nrst);

    // latch mode while idle; follow addresses while busy
    always_ff @(posedge clk) begin
        if (!nrst || !busy) begin
            desc_q <= desc_start;
            fifo_q <= !desc_start && fifo_start; // descriptor wins
            rd_q   <= fifo_read;
            nb_q   <= desc_start ? !bdesc : !fifo_burst;
            nxt_q  <= {fifo_addr[31:2], 2'h0};
            seen_q <= 1'b0;
            cmd_q  <= 4'h0;
        end else if ($fell(frame_n_out)) begin
            seen_q <= 1'b1;
            cmd_q  <= cbe_n_out;
        end else if (!irdy_n_out && !trdy_n) begin
            nxt_q  <= nxt_q + ADDR_STEP;
        end
    end

    a_linear_order: assert property ($fell(frame_n_out)
        |-> ad_out[1:0] == LINEAR_ORDER) else $error("low address bits set");
    a_grant_first: assert property ($fell(frame_n_out)
        |-> !$past(gnt_n)) else $error("address phase without grant");
    a_start_request: assert property (go
        |=> !req_n && busy) else $error("start not followed by request");
    a_desc_wait: assert property (desc_q && $fell(frame_n_out)
        |=> irdy_n_out ##1 !irdy_n_out) else $error("no wait state");
    a_burst_wait: assert property (desc_q && !frame_n_out
        && !irdy_n_out && !trdy_n |=> irdy_n_out) else $error("no wait");
    a_same_dir: assert property (seen_q && $fell(frame_n_out)
        |-> cbe_n_out == cmd_q) else $error("direction changed");
    a_fifo_ascend: assert property (fifo_q && $fell(frame_n_out)
        |-> ad_out == nxt_q) else $error("fifo address not contiguous");
    a_single_addr: assert property (nb_q && $fell(frame_n_out)
        |=> frame_n_out) else $error("frame held in single transfer");
    a_hold_phase: assert property (!irdy_n_out && trdy_n
        |=> !irdy_n_out && $stable(cbe_n_out)) else $error("phase dropped");
    a_read_return: assert property (fifo_q && rd_q && !irdy_n_out
        && !trdy_n |=> rd_valid && rd_data == $past(ad_in))
        else $error("read word not returned");
    a_data_drive: assert property (!irdy_n_out
        |-> ad_oe == !(fifo_q && rd_q)) else $error("ad drive wrong in phase");
endmodule

`default_nettype wire

// File: pci_mem_model.sv
// arbiter and memory target on the far side of the bus master
`timescale 1ns/100ps
`default_nettype none

module pci_mem_model
    import dma_master_pkg::*;
(
    input  wire logic        clk, nrst, req_n, frame_n, irdy_n, stall,
    input  wire logic [31:0] ad,
    input  wire logic [3:0]  cbe_n,
    output logic             gnt_n, trdy_n, ev,
    output logic [31:0]      ad_in, ev_addr, ev_data,
    output logic [3:0]       ev_be
);
    logic        fr_q;                             // frame last cycle
    logic [31:0] a_q;                              // current address
    logic [3:0]  c_q;                              // latched command
    wire         xfer = !irdy_n && !trdy_n;        // phase completes
    wire  [31:0] word = {a_q[15:0], ~a_q[31:16]};  // memory contents

    // ready only while the master waits; random stalls slow it down
    assign trdy_n = irdy_n || stall;
    // read data only in a read phase, else a pattern that keeps moving
    assign ad_in = (c_q == CMD_MEM_READ && !irdy_n) ? word : ~word;

    // grant a cycle after request; decode address and data phases
    always_ff @(posedge clk) begin
        gnt_n   <= !nrst || req_n;
        fr_q    <= frame_n;
        ev      <= xfer && c_q == CMD_MEM_WRITE;
        ev_addr <= a_q;
        ev_data <= ad;
        ev_be   <= cbe_n;
        if (fr_q && !frame_n) begin
            a_q <= ad;
            c_q <= cbe_n;
        end else if (xfer) begin
            a_q <= a_q + ADDR_STEP;            // linear burst order
        end
    end
endmodule

`default_nettype wire

// File: testbench.sv
// self-checking bench for the descriptor and fifo bus master
`timescale 1ns/100ps
`default_nettype none

module testbench;
    import dma_master_pkg::*;
    logic        clk = 0, nrst = 0, stall = 0, fr_q = 1;
    logic        desc_start = 0, fifo_start = 0, fifo_read = 0;
    logic        fifo_burst = 0, fifo_more = 0, wr_valid = 0;
    logic [31:0] fifo_addr = 0, wr_data = 0, ra = 0, wbase = 0;
    desc_req_t   desc_req = '0;
    logic        wr_ready, rd_valid, busy, done, req_n, gnt_n, trdy_n;
    logic        frame_n_out, frame_n_oe, irdy_n_out, irdy_n_oe;
    logic        ad_oe, cbe_n_oe, ev;
    logic [3:0]  cbe_n_out, ev_be;
    logic [31:0] ad_in, ad_out, rd_data, ev_addr, ev_data;
    logic [67:0] exp_q[$];                      // expected write phases
    logic [7:0]  st_tab[4] = '{STYLE_16BIT, STYLE_32BIT, STYLE_BURST, 8'h05};
    int          mismatches = 0, tests_run = 0;
    int          n_addr, n_xfer, n_rd, k, n_want;
    // released control lines float high on their pull-ups
    wire         frame_w = frame_n_oe ? frame_n_out : 1'b1;
    wire         irdy_w = irdy_n_oe ? irdy_n_out : 1'b1;

    always #10 clk = ~clk;

    dma_bus_master uut (.clk(clk), .nrst(nrst), .desc_start(desc_start),
        .desc_req(desc_req), .fifo_start(fifo_start), .fifo_read(fifo_read),
        .fifo_burst(fifo_burst), .fifo_addr(fifo_addr),
        .fifo_more(fifo_more), .wr_valid(wr_valid), .wr_data(wr_data),
        .wr_ready(wr_ready), .rd_valid(rd_valid), .rd_data(rd_data),
        .busy(busy), .done(done), .req_n(req_n), .gnt_n(gnt_n),
        .frame_n_in(frame_w), .frame_n_out(frame_n_out),
        .frame_n_oe(frame_n_oe), .irdy_n_in(irdy_w),
        .irdy_n_out(irdy_n_out), .irdy_n_oe(irdy_n_oe), .trdy_n(trdy_n),
        .ad_in(ad_in), .ad_out(ad_out), .ad_oe(ad_oe),
        .cbe_n_out(cbe_n_out), .cbe_n_oe(cbe_n_oe));
    pci_mem_model far (.clk(clk), .nrst(nrst), .req_n(req_n),
        .frame_n(frame_w), .irdy_n(irdy_w), .stall(stall), .ad(ad_out),
        .cbe_n(cbe_n_out), .gnt_n(gnt_n), .trdy_n(trdy_n), .ev(ev),
        .ad_in(ad_in), .ev_addr(ev_addr), .ev_data(ev_data), .ev_be(ev_be));

    function automatic logic [31:0] mem_word(input logic [31:0] a);
        return {a[15:0], ~a[31:16]};
    endfunction

    task automatic chk(input logic [67:0] got, input logic [67:0] exp);
        tests_run++;
        if (got !== exp) begin
            mismatches++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic summarize();
        $display("checks %0d mismatches %0d", tests_run, mismatches);
        if (mismatches == 0 && tests_run > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    // ******************************
    // bus monitor and stream drivers
    // ******************************
    always @(posedge clk) begin
        if (fr_q && !frame_w) n_addr++;
        fr_q = frame_w;
        if (!irdy_w && !trdy_n) n_xfer++;
        if (wr_ready) k++;
        if (ev) chk({ev_addr, ev_data, ev_be}, exp_q.pop_front());
        if (rd_valid) begin
            chk(rd_data, mem_word(ra));
            ra += 32'h4;
            n_rd++;
        end
    end

    // slow target at random; more wanted until n words moved
    always @(negedge clk) begin
        stall     <= ($urandom % 3) == 0;
        wr_data   <= wbase + k;
        // a burst data phase decides the word after the one it loads next
        fifo_more <= n_xfer + ((fifo_burst && !irdy_w) ? 2 : 1) < n_want;
    end

    // one period: a start that is refused while busy, then the ending
    task automatic run(input int addrs);
        int i;
        n_addr = 0; n_xfer = 0; n_rd = 0; k = 0;
        @(negedge clk);
        desc_start = 0;
        fifo_start = 0;
        for (i = 0; i < 400 && !done; i++) begin
            @(negedge clk);
            fifo_start = (i == 3) && !done;
        end
        @(negedge clk);
        chk({busy, i < 400, exp_q.size()}, {2'b01, 32'h0});
        chk(n_addr, addrs);
    endtask

    task automatic run_desc(input logic [7:0] st, input logic bw);
        logic [31:0] b, w1, w2;
        b  = $urandom & 32'hFFFF_FFF0;
        w1 = $urandom;
        w2 = $urandom;
        if (st == STYLE_16BIT) begin
            exp_q.push_back({b + 32'h4, w2[15:0], w1[15:0], 4'h0});
            exp_q.push_back({b, w1[31:24], 24'h0, 4'h7});
        end else begin
            exp_q.push_back({b + (st == STYLE_BURST ? 32'h0 : 32'h8), w2, 4'h0});
            exp_q.push_back({b + 32'h4, w1[31:16], 16'h0, 4'h3});
        end
        desc_req = '{b, w1, w2, st, bw};
        fifo_start = 1;                         // descriptor must win
        desc_start = 1;
        run(st == STYLE_BURST && bw ? 1 : 2);
    endtask

    task automatic run_fifo(input logic rd, input logic bu, input int n);
        int j;
        fifo_addr = $urandom;
        wbase = $urandom;
        ra = fifo_addr & 32'hFFFF_FFFC;
        for (j = 0; j < n; j++)
            if (!rd) exp_q.push_back({ra + 4 * j, wbase + j, 4'h0});
        n_want = n;
        fifo_read = rd;
        fifo_burst = bu;
        wr_valid = !rd;
        fifo_start = 1;
        run(bu ? 1 : n);
        chk({n_xfer, n_rd}, {n, rd ? n : 0});
    endtask

    initial begin
        void'($urandom(76));
        repeat (2) @(negedge clk);
        nrst = 1;
        chk({busy, req_n, frame_n_oe, irdy_n_oe, ad_oe, cbe_n_oe, cbe_n_out},
            10'b0100001111);
        // first request only once a clock edge has passed out of reset
        @(negedge clk);
        for (int s = 0; s < 4; s++)
            for (int b = 0; b < 2; b++) begin
                run_desc(st_tab[s], b[0]);
                $display("descriptor style %h burst %0d done", st_tab[s], b);
            end
        for (int r = 0; r < 12; r++) begin
            run_fifo(r[0], r[1], r < 4 ? 1 : 2 + $urandom % 6);
            $display("fifo read %0d burst %0d done", r[0], r[1]);
        end
        summarize();
    end

    // watchdog far beyond the few hundred cycles the run needs
    initial begin
        #(20 * 20000);
        mismatches++;
        summarize();
    end
endmodule

bind dma_bus_master dma_bus_master_asserts checks (.clk(clk), .nrst(nrst),
    .desc_start(desc_start), .fifo_start(fifo_start), .fifo_read(fifo_read),
    .fifo_burst(fifo_burst), .rd_valid(rd_valid), .busy(busy),
    .req_n(req_n), .gnt_n(gnt_n), .ad_oe(ad_oe), .frame_n_out(frame_n_out),
    .irdy_n_out(irdy_n_out), .trdy_n(trdy_n), .desc_req(desc_req),
    .fifo_addr(fifo_addr), .ad_in(ad_in), .ad_out(ad_out),
    .rd_data(rd_data), .cbe_n_out(cbe_n_out));

`default_nettype wire
